// ### hw/spc_pkg.sv
// Purpose: Shared constants and carriers for the streaming port channel
// Assumes: One channel, 32-bit word per item, core-side register window
// Notes: Offsets are byte offsets inside the channel window
package spc_pkg;
   localparam int DATA_W = 32;
   localparam int FIFO_DEPTH = 16;
   localparam int ADDR_W = 6;
   // Register byte offsets
   localparam logic [5:0] OFS_DATA = 6'h00;
   localparam logic [5:0] OFS_READY = 6'h08;
   localparam logic [5:0] OFS_CONTROL = 6'h10;
   localparam logic [5:0] OFS_RELOAD = 6'h18;
   localparam logic [5:0] OFS_COUNTDOWN = 6'h20;
   // Control field positions
   localparam int CTL_ACCESS_LEVEL_FIELD_LSB = 0;
   localparam int CTL_RST_IN = 2;
   localparam int CTL_RST_OUT = 3;
   localparam int CTL_DIR_IN = 4;
   localparam int CTL_MASTER = 6;
   localparam int CTL_TO_DIS = 7;
   // Access level field values
   localparam logic [1:0] ACCESS_LEVEL_FIELD_SUPERVISOR_ONLY = 2'h0;
   localparam logic [1:0] USER_ALLOWED_ALLOWED = 2'h1;
   // Values after reset
   localparam logic [31:0] CONTROL_RST = 32'h0000_0000;
   localparam logic [31:0] RELOAD_RST = 32'h0000_1000;
   localparam logic [31:0] COUNTDOWN_RST = 32'h0000_1000;

   typedef struct packed {
      logic valid;
      logic wr;
      logic user;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } spc_req_type;

   typedef struct packed {
      logic done;
      logic stall;
      logic timeout;
      logic prot_err;
      logic map_err;
      logic [DATA_W-1:0] rdata;
   } spc_rsp_type;

   typedef enum logic {
      ST_IDLE,
      ST_HOLD
   } spc_state_type;
endpackage : spc_pkg

// ### hw/spc_fifo.sv
// Purpose: Word FIFO between the core side and the peripheral side
// Assumes: DEPTH is a power of two
// Notes: flush_i empties the FIFO in one cycle
`timescale 1ns/100ps
`default_nettype none
module spc_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic flush_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o,
   output logic [$clog2(DEPTH):0] count_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [WIDTH-1:0] mem_nxt [DEPTH];
   logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic push, pop;

   assign in_ready_o = (cnt_r != DEPTH[AW:0]);
   assign out_valid_o = (cnt_r != '0);
   assign out_data_o = mem_r[rd_r];
   assign count_o = cnt_r;
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // Strict first-in first-out order
   always_comb begin
      wr_nxt = push ? wr_r + 1'b1 : wr_r;
      rd_nxt = pop ? rd_r + 1'b1 : rd_r;
      cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      if (flush_i) begin
         wr_nxt = '0;
         rd_nxt = '0;
         cnt_nxt = '0;
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
      end else begin
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   for (genvar g = 0; g < DEPTH; g++) begin : g_entry
      always_comb begin
         mem_nxt[g] = (push && !flush_i && wr_r == AW'(g)) ? in_data_i : mem_r[g];
      end
      always_ff @(posedge clk_sys_i or negedge resetn_i) begin
         if (!resetn_i) begin
            mem_r[g] <= '0;
         end else begin
            mem_r[g] <= mem_nxt[g];
         end
      end
   end
endmodule : spc_fifo
`default_nettype wire

// ### hw/spc_channel.sv
// Purpose: One streaming port channel between core load/store unit and a peripheral
// Assumes: Core holds a request until done, or drops it when it takes an interrupt
// Notes: Direction and master role are build parameters shown in the control register
`timescale 1ns/100ps
`default_nettype none
module spc_channel #(
   parameter bit DIRECTION_IS_IN = 1'b0,
   parameter bit END_IS_MASTER = 1'b1
) (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire spc_pkg::spc_req_type req_i,
   input wire logic intr_i,
   output spc_pkg::spc_rsp_type rsp_o,
   input wire logic pin_valid_i,
   input wire logic [spc_pkg::DATA_W-1:0] pin_data_i,
   output logic pin_ready_o,
   output logic pout_valid_o,
   output logic [spc_pkg::DATA_W-1:0] pout_data_o,
   input wire logic pout_ready_i,
   input wire logic incoming_reset_line_i,
   output logic outgoing_reset_line_o
);
   localparam int CW = $clog2(spc_pkg::FIFO_DEPTH) + 1;

   spc_pkg::spc_state_type state_r, state_nxt;
   spc_pkg::spc_rsp_type rsp_r, rsp_nxt;
   logic [1:0] access_level_field_r, access_level_field_nxt;
   logic rst_out_r, rst_out_nxt;
   logic to_dis_r, to_dis_nxt;
   logic [31:0] reload_r, reload_nxt;
   logic [31:0] countdown_r, countdown_nxt;
   logic rst_in_meta_r, rst_in_sync_r;
   logic soft_rst;
   logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
   logic [spc_pkg::DATA_W-1:0] fifo_in_data, fifo_out_data;
   logic [CW-1:0] fifo_count;
   logic core_push, core_pop;
   logic is_data, is_ready, is_ctl, is_rel, is_cnt, mapped, allowed, chan_ok;
   logic [31:0] ready_level, ctl_word;

   // Incoming line is from the far end, so it is synchronised first
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_in_meta_r <= 1'b0;
         rst_in_sync_r <= 1'b0;
      end else begin
         rst_in_meta_r <= incoming_reset_line_i;
         rst_in_sync_r <= rst_in_meta_r;
      end
   end

   // Master is in reset while it requests; slave while the request stands
   assign soft_rst = END_IS_MASTER ? rst_out_r : rst_in_sync_r;

   // FIFO faces the peripheral on one side and the core on the other
   assign fifo_in_valid = DIRECTION_IS_IN ? (pin_valid_i && !soft_rst) : core_push;
   assign fifo_in_data = DIRECTION_IS_IN ? pin_data_i : req_i.wdata;
   assign fifo_out_ready = DIRECTION_IS_IN ? core_pop : pout_ready_i;
   // In reset every presented item is consumed and dropped
   assign pin_ready_o = DIRECTION_IS_IN && (fifo_in_ready || soft_rst);
   assign pout_valid_o = !DIRECTION_IS_IN && fifo_out_valid && !soft_rst;
   assign pout_data_o = fifo_out_data;

   spc_fifo #(
      .WIDTH(spc_pkg::DATA_W),
      .DEPTH(spc_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .flush_i(soft_rst), // Buffered data is discarded
      .in_valid_i(fifo_in_valid),
      .in_ready_o(fifo_in_ready),
      .in_data_i(fifo_in_data),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_out_ready),
      .out_data_o(fifo_out_data),
      .count_o(fifo_count)
   );

   assign is_data = (req_i.addr == spc_pkg::OFS_DATA);
   assign is_ready = (req_i.addr == spc_pkg::OFS_READY);
   assign is_ctl = (req_i.addr == spc_pkg::OFS_CONTROL);
   assign is_rel = (req_i.addr == spc_pkg::OFS_RELOAD);
   assign is_cnt = (req_i.addr == spc_pkg::OFS_COUNTDOWN);
   assign mapped = is_data || is_ready || is_ctl || is_rel || is_cnt;
   // Only value 1 opens user access, and only to data and ready
   assign allowed = !req_i.user
      || ((access_level_field_r == spc_pkg::USER_ALLOWED_ALLOWED) && (is_data || is_ready));
   // Channel can take the transfer now
   assign chan_ok = !soft_rst && (DIRECTION_IS_IN ? fifo_out_valid : fifo_in_ready);
   assign core_push = !DIRECTION_IS_IN && state_r == spc_pkg::ST_IDLE && req_i.valid
      && req_i.wr && is_data && allowed && chan_ok;
   assign core_pop = DIRECTION_IS_IN && state_r == spc_pkg::ST_IDLE && req_i.valid
      && !req_i.wr && is_data && allowed && chan_ok;

   // Ready level is exact outside soft reset and reads zero during it, which meets the minimum-count promise
   always_comb begin
      ready_level = '0;
      if (!soft_rst) begin
         if (DIRECTION_IS_IN) begin
            ready_level = 32'(fifo_count);
         end else begin
            ready_level = 32'(CW'(spc_pkg::FIFO_DEPTH) - fifo_count);
         end
      end
   end

   // Read-only bits report role and incoming line
   always_comb begin
      ctl_word = '0;
      ctl_word[spc_pkg::CTL_ACCESS_LEVEL_FIELD_LSB +: 2] = access_level_field_r;
      ctl_word[spc_pkg::CTL_RST_IN] = rst_in_sync_r;
      ctl_word[spc_pkg::CTL_RST_OUT] = rst_out_r;
      ctl_word[spc_pkg::CTL_DIR_IN] = DIRECTION_IS_IN;
      ctl_word[spc_pkg::CTL_MASTER] = END_IS_MASTER;
      ctl_word[spc_pkg::CTL_TO_DIS] = to_dis_r;
   end

   always_comb begin
      state_nxt = state_r;
      rsp_nxt = '0;
      access_level_field_nxt = access_level_field_r;
      rst_out_nxt = rst_out_r;
      to_dis_nxt = to_dis_r;
      reload_nxt = reload_r;
      countdown_nxt = countdown_r;
      case (state_r)
         spc_pkg::ST_IDLE: begin
            if (req_i.valid) begin
               if (!mapped) begin
                  rsp_nxt.done = 1'b1;
                  rsp_nxt.map_err = 1'b1;
                  state_nxt = spc_pkg::ST_HOLD;
               end else if (!allowed) begin
                  rsp_nxt.done = 1'b1;
                  rsp_nxt.prot_err = 1'b1;
                  state_nxt = spc_pkg::ST_HOLD;
               end else if (is_data) begin
                  if (DIRECTION_IS_IN == req_i.wr) begin
                     // Wrong-way data access completes at once, reads zero
                     rsp_nxt.done = 1'b1;
                     state_nxt = spc_pkg::ST_HOLD;
                  end else if (chan_ok) begin
                     rsp_nxt.done = 1'b1;
                     rsp_nxt.rdata = DIRECTION_IS_IN ? fifo_out_data : '0;
                     countdown_nxt = reload_r;
                     state_nxt = spc_pkg::ST_HOLD;
                  end else if (intr_i) begin
                     // Access dropped; countdown keeps its value for the retry
                     rsp_nxt.stall = 1'b0;
                  end else if (countdown_r == '0 && !to_dis_r) begin
                     // Countdown already spent: flag timeout, hold zero
                     rsp_nxt.done = 1'b1;
                     rsp_nxt.timeout = 1'b1;
                     state_nxt = spc_pkg::ST_HOLD;
                  end else begin
                     rsp_nxt.stall = 1'b1;
                     if (countdown_r != '0) begin
                        countdown_nxt = countdown_r - 32'h0000_0001;
                     end
                  end
               end else begin
                  rsp_nxt.done = 1'b1;
                  state_nxt = spc_pkg::ST_HOLD;
                  if (req_i.wr) begin
                     if (is_ctl) begin
                        access_level_field_nxt = req_i.wdata[spc_pkg::CTL_ACCESS_LEVEL_FIELD_LSB +: 2];
                        rst_out_nxt = req_i.wdata[spc_pkg::CTL_RST_OUT];
                        to_dis_nxt = req_i.wdata[spc_pkg::CTL_TO_DIS];
                     end
                     if (is_rel) begin
                        reload_nxt = req_i.wdata;
                     end
                     if (is_cnt) begin
                        countdown_nxt = req_i.wdata;
                     end
                  end else begin
                     rsp_nxt.rdata = is_ready ? ready_level
                        : is_ctl ? ctl_word
                        : is_rel ? reload_r
                        : countdown_r;
                  end
               end
            end
         end
         spc_pkg::ST_HOLD: begin
            // Waits for the core to drop the finished request
            if (!req_i.valid) begin
               state_nxt = spc_pkg::ST_IDLE;
            end
         end
         default: begin
            state_nxt = spc_pkg::ST_IDLE;
         end
      endcase
   end

   // Soft reset touches neither countdown nor reload value
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_r <= spc_pkg::ST_IDLE;
         rsp_r <= '0;
         access_level_field_r <= spc_pkg::CONTROL_RST[spc_pkg::CTL_ACCESS_LEVEL_FIELD_LSB +: 2];
         rst_out_r <= spc_pkg::CONTROL_RST[spc_pkg::CTL_RST_OUT];
         to_dis_r <= spc_pkg::CONTROL_RST[spc_pkg::CTL_TO_DIS];
         reload_r <= spc_pkg::RELOAD_RST;
         countdown_r <= spc_pkg::COUNTDOWN_RST;
      end else begin
         state_r <= state_nxt;
         rsp_r <= rsp_nxt;
         access_level_field_r <= access_level_field_nxt;
         rst_out_r <= rst_out_nxt;
         to_dis_r <= to_dis_nxt;
         reload_r <= reload_nxt;
         countdown_r <= countdown_nxt;
      end
   end

   assign rsp_o = rsp_r;
   assign outgoing_reset_line_o = rst_out_r;
endmodule : spc_channel
`default_nettype wire

// ### sim/spc_channel_props.sv
// Purpose: Port assertions for one streaming port channel
// Assumes: Output channel, master end
// Notes: Watches the core request side, the peripheral output side and the outgoing reset line only
`timescale 1ns/100ps
`default_nettype none
module spc_chk (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire spc_pkg::spc_req_type req_i,
   input wire logic intr_i,
   input wire spc_pkg::spc_rsp_type rsp_o,
   input wire logic pout_valid_o,
   input wire logic [31:0] pout_data_o,
   input wire logic pout_ready_i,
   input wire logic outgoing_reset_line_o
);
   logic ctl_wr;
   assign ctl_wr = req_i.valid && req_i.wr && req_i.addr == spc_pkg::OFS_CONTROL;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   sequence s_new(logic [5:0] a, logic u, logic w);
      $rose(req_i.valid) && req_i.addr == a && req_i.user == u && req_i.wr == w;
   endsequence
   sequence s_held;
      pout_valid_o && !pout_ready_i ##1 !outgoing_reset_line_o;
   endsequence
   user_ctl_a: assert property (s_new(spc_pkg::OFS_CONTROL, 1'b1, 1'b0) |=>
      rsp_o.done && rsp_o.prot_err) else $error("user control access not refused");
   out_read_a: assert property (s_new(spc_pkg::OFS_DATA, 1'b0, 1'b0) |=>
      rsp_o.done && rsp_o.rdata == 32'h0) else $error("output data read not zero");
   ctl_write_a: assert property ($changed(outgoing_reset_line_o) |->
      $past(ctl_wr) && rsp_o.done) else $error("reset line moved without write");
   soft_flush_a: assert property (outgoing_reset_line_o |-> !pout_valid_o)
      else $error("data offered during soft reset");
   stall_excl_a: assert property (rsp_o.stall |-> !rsp_o.done)
      else $error("done during stall");
   intr_stop_a: assert property (intr_i && rsp_o.stall |=> !rsp_o.done)
      else $error("access completed after interrupt");
   hold_data_a: assert property (s_held |-> pout_valid_o && $stable(pout_data_o))
      else $error("offered word changed before taken");
   timeout_done_a: assert property (rsp_o.timeout |-> rsp_o.done ##1 !rsp_o.timeout)
      else $error("timeout not a single done pulse");
endmodule : spc_chk
bind spc_channel spc_chk u_chk (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .req_i(req_i),
   .intr_i(intr_i), .rsp_o(rsp_o), .pout_valid_o(pout_valid_o), .pout_data_o(pout_data_o),
   .pout_ready_i(pout_ready_i), .outgoing_reset_line_o(outgoing_reset_line_o));
`default_nettype wire

// ### sim/spc_sink.sv
// Purpose: Slave peripheral taking words from an output channel
// Assumes: Same clock as the core side
// Notes: Ready is random so the FIFO sees both prompt and slow draining
`timescale 1ns/100ps
`default_nettype none
module spc_sink (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic hold_i,
   input wire logic pout_valid_i,
   input wire logic [31:0] pout_data_i,
   output logic pout_ready_o,
   input wire logic reset_req_i,
   output logic reset_ack_o
);
   logic [31:0] got [$];
   logic [2:0] ack_r;
   int pseed = 32'h0bad_5eed;
   assign reset_ack_o = ack_r[2];
   always @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ack_r <= 3'h0;
         pout_ready_o <= 1'b0;
      end else begin
         // Ack lags the request, as if a deeper slave chain answered
         ack_r <= {ack_r[1:0], reset_req_i};
         // Everything presented is swallowed while in reset
         pout_ready_o <= reset_req_i || (!hold_i && ($random(pseed) & 32'h3) != 0);
         if (pout_valid_i && pout_ready_o && !reset_req_i) begin
            got.push_back(pout_data_i);
         end
      end
   end
endmodule : spc_sink
`default_nettype wire

// ### sim/tb.sv
// Purpose: Self-checking bench for an output master channel
// Assumes: Core requests held until done, dropped after an interrupt
// Notes: Input-channel behaviour needs a second build and is not run here
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic clk_sys_i = 1'b0;
   logic resetn_i = 1'b0;
   logic intr = 1'b0;
   logic hold = 1'b1;
   logic pv, pr, ack, rq;
   logic [31:0] pd, cd;
   logic [31:0] sent [$];
   spc_pkg::spc_req_type req = '0;
   spc_pkg::spc_rsp_type rsp, r;
   int seed = 32'h02dd90c7;
   int mismatches = 0;
   int checked = 0;
   int cyc = 0;
   initial forever #50 clk_sys_i = ~clk_sys_i;
   spc_channel DUT (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .req_i(req), .intr_i(intr),
      .rsp_o(rsp), .pin_valid_i(1'b0), .pin_data_i(32'h0), .pin_ready_o(), .pout_valid_o(pv),
      .pout_data_o(pd), .pout_ready_i(pr), .incoming_reset_line_i(ack),
      .outgoing_reset_line_o(rq));
   spc_sink peer (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .hold_i(hold),
      .pout_valid_i(pv), .pout_data_i(pd), .pout_ready_o(pr), .reset_req_i(rq),
      .reset_ack_o(ack));
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Free slots an output channel must report while holding this many words
   function automatic logic [31:0] free_slots(input int items);
      return 32'(spc_pkg::FIFO_DEPTH - items);
   endfunction : free_slots
   task final_report;
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report
   // Interrupt stays up one edge with valid still high, so the channel drops the stalled access
   task acc(input logic w, input logic u, input logic [5:0] a, input logic [31:0] d,
      input int ab);
      int n;
      n = 0;
      r = '0;
      @(posedge clk_sys_i) req <= '{1'b1, w, u, a, d};
      repeat (3000) begin
         @(posedge clk_sys_i);
         #1 r = rsp;
         if (r.done) break;
         if (ab > 0 && n++ == ab) break;
      end
      @(posedge clk_sys_i) intr <= (ab > 0 && !r.done);
      @(posedge clk_sys_i) intr <= 1'b0;
      req.valid <= 1'b0;
      @(posedge clk_sys_i);
   endtask : acc
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         final_report();
      end
   end
   initial begin
      repeat (3) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      acc(1'b0, 1'b0, spc_pkg::OFS_CONTROL, 32'h0, 0);
      chk(r.rdata, spc_pkg::CONTROL_RST | (32'h1 << spc_pkg::CTL_MASTER));
      acc(1'b0, 1'b0, spc_pkg::OFS_RELOAD, 32'h0, 0);
      chk(r.rdata, spc_pkg::RELOAD_RST);
      acc(1'b0, 1'b0, spc_pkg::OFS_COUNTDOWN, 32'h0, 0);
      chk(r.rdata, spc_pkg::COUNTDOWN_RST);
      acc(1'b0, 1'b0, spc_pkg::OFS_READY, 32'h0, 0);
      chk(r.rdata, free_slots(0));
      $display("reset values test done");
      for (int p = 0; p < 4; p++) begin
         if (p > 0) acc(1'b1, 1'b0, spc_pkg::OFS_CONTROL, 32'(p), 0);
         acc(1'b0, 1'b1, spc_pkg::OFS_READY, 32'h0, 0);
         chk(r.prot_err, p != 1);
         acc(1'b0, 1'b1, spc_pkg::OFS_CONTROL, 32'h0, 0);
         chk(r.prot_err, 1'b1);
      end
      acc(1'b1, 1'b0, spc_pkg::OFS_CONTROL, 32'h1, 0);
      acc(1'b0, 1'b1, spc_pkg::OFS_DATA, 32'h0, 0);
      chk({r.done, r.prot_err}, 2'b10);
      chk(r.rdata, 32'h0);
      acc(1'b0, 1'b0, spc_pkg::OFS_DATA, 32'h0, 0);
      chk({r.done, r.stall}, 2'b10);
      chk(r.rdata, 32'h0);
      acc(1'b0, 1'b0, 6'h28, 32'h0, 0);
      chk(r.map_err, 1'b1);
      $display("access rights test done");
      repeat (16) begin
         sent.push_back($random(seed));
         acc(1'b1, 1'b0, spc_pkg::OFS_DATA, sent[$], 0);
      end
      acc(1'b0, 1'b0, spc_pkg::OFS_READY, 32'h0, 0);
      chk(r.rdata, free_slots(16));
      acc(1'b1, 1'b0, spc_pkg::OFS_COUNTDOWN, 32'h5, 0);
      acc(1'b1, 1'b0, spc_pkg::OFS_DATA, 32'h0, 0);
      chk({r.done, r.timeout}, 2'b11);
      acc(1'b0, 1'b0, spc_pkg::OFS_COUNTDOWN, 32'h0, 0);
      chk(r.rdata, 32'h0);
      $display("full and timeout test done");
      acc(1'b1, 1'b0, spc_pkg::OFS_CONTROL, 32'h81, 0);
      // Timeouts off: a spent countdown must keep stalling, not time out
      acc(1'b1, 1'b0, spc_pkg::OFS_COUNTDOWN, 32'h3, 0);
      acc(1'b1, 1'b0, spc_pkg::OFS_DATA, 32'h0, 10);
      chk({r.done, r.timeout}, 2'b00);
      acc(1'b0, 1'b0, spc_pkg::OFS_COUNTDOWN, 32'h0, 0);
      chk(r.rdata, 32'h0);
      acc(1'b1, 1'b0, spc_pkg::OFS_COUNTDOWN, 32'h28, 0);
      sent.push_back($random(seed));
      acc(1'b1, 1'b0, spc_pkg::OFS_DATA, sent[$], 10);
      chk(r.done, 1'b0);
      acc(1'b0, 1'b0, spc_pkg::OFS_COUNTDOWN, 32'h0, 0);
      cd = r.rdata;
      chk(cd > 0 && cd < 32'h28, 1'b1);
      @(posedge clk_sys_i) hold <= 1'b0;
      acc(1'b1, 1'b0, spc_pkg::OFS_DATA, sent[$], 0);
      chk({r.done, r.timeout}, 2'b10);
      acc(1'b0, 1'b0, spc_pkg::OFS_COUNTDOWN, 32'h0, 0);
      chk(r.rdata, spc_pkg::RELOAD_RST);
      repeat (200) @(posedge clk_sys_i);
      chk(peer.got.size(), sent.size());
      foreach (sent[i]) chk(peer.got[i], sent[i]);
      $display("order and interrupt test done");
      @(posedge clk_sys_i) hold <= 1'b1;
      repeat (3) acc(1'b1, 1'b0, spc_pkg::OFS_DATA, $random(seed), 0);
      acc(1'b1, 1'b0, spc_pkg::OFS_CONTROL, 32'h89, 0); // Only control is polled in reset
      for (int k = 0; k < 20 && !r.rdata[2]; k++) acc(1'b0, 1'b0, spc_pkg::OFS_CONTROL, 0, 0);
      chk(r.rdata[2], 1'b1);
      acc(1'b1, 1'b0, spc_pkg::OFS_CONTROL, 32'h81, 0);
      r.rdata = 32'h4;
      for (int k = 0; k < 20 && r.rdata[2]; k++) acc(1'b0, 1'b0, spc_pkg::OFS_CONTROL, 0, 0);
      chk(r.rdata[2], 1'b0);
      acc(1'b0, 1'b0, spc_pkg::OFS_READY, 32'h0, 0);
      chk(r.rdata, free_slots(0));
      acc(1'b0, 1'b0, spc_pkg::OFS_COUNTDOWN, 32'h0, 0);
      chk(r.rdata, spc_pkg::RELOAD_RST);
      @(posedge clk_sys_i) hold <= 1'b0;
      repeat (50) @(posedge clk_sys_i);
      chk(peer.got.size(), sent.size());
      $display("soft reset test done");
      final_report();
   end
endmodule : tb
`default_nettype wire
